// ===== nvm_access_pkg.sv
package nvm_access_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          BUS_ADDR_W     = 4;
  localparam logic [3:0]  OFS_ADDRESS    = 4'h0;
  localparam logic [3:0]  OFS_DATA       = 4'h1;
  localparam logic [3:0]  OFS_CONTROL    = 4'h2;
  localparam logic [3:0]  OFS_UNLOCK     = 4'h3;
  localparam logic [3:0]  OFS_FLAGS      = 4'h4;
  localparam logic [3:0]  OFS_INT_MASK   = 4'h5;
  localparam logic [3:0]  OFS_PRIORITY   = 4'h6;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          DONE_BIT       = 4;
  localparam logic [7:0]  ADDRESS_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic        FLAGS_RESET    = 1'b0;
  localparam logic        MASK_RESET     = 1'b0;
  localparam logic        PRIORITY_RESET = 1'b1;
  localparam logic [7:0]  UNLOCK_KEY1    = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2    = 8'hAA;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam int          MEM_DEPTH      = 256;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          WRITE_TIME_US  = 4000;
  localparam int          WRITE_CYCLES_DEFAULT = WRITE_TIME_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SPACE_DATA = 2'b00,
    SPACE_PROG = 2'b01,
    SPACE_CFG  = 2'b10
  } space_t;

  typedef enum logic [2:0] {
    UL_IDLE  = 3'b001,
    UL_KEY1  = 3'b010,
    UL_ARMED = 3'b100
  } unlock_state_t;

  typedef struct packed {
    logic program_memory_select;
    logic config_space_select;
    logic unused;
    logic row_erase;
    logic write_error_flag;
    logic erase_write_enable;
    logic write_start;
    logic read_start;
  } ctrl_t;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_t;

  typedef struct packed {
    logic       strobe;
    space_t     space;
    logic       row_erase;
    logic [7:0] addr;
    logic [7:0] data;
  } ext_req_t;

endpackage : nvm_access_pkg

// ===== nvm_access_control.sv
// Local design decisions: the register addresses and strobed register access.
module nvm_access_control #(
  parameter int unsigned WRITE_CYCLES = nvm_access_pkg::WRITE_CYCLES_DEFAULT
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rstn,
  input  wire nvm_access_pkg::reg_req_t  i_bus,
  input  wire logic                      i_external_master_reset,
  input  wire logic                      i_watchdog_timeout,
  input  wire logic [7:0]                i_config_byte,
  output logic [7:0]                     o_rdata,
  output logic                           o_irq,
  output logic                           o_nvm_done_priority,
  output logic                           o_busy,
  output nvm_access_pkg::ext_req_t       o_ext_req
);
  import nvm_access_pkg::*;

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  if (WRITE_CYCLES < 2) begin : g_check
    $error("WRITE_CYCLES must be at least 2");
  end

  // ****************************************
  // state
  // ****************************************
  logic [7:0]    nvm_address_byte;
  logic [7:0]    nvm_data_byte;
  ctrl_t         ctrl;
  logic          nvm_done_flag;
  logic          nvm_done_int_mask;
  logic          nvm_done_priority;
  unlock_state_t ul_state;
  unlock_state_t next_ul_state;
  logic [CNT_W-1:0] cnt;
  space_t        op_space;
  logic [7:0]    op_addr;
  logic [7:0]    op_data;
  logic          op_erase;
  logic          rd_cfg;
  logic [7:0]    mem [MEM_DEPTH];

  // ****************************************
  // decode
  // ****************************************
  wire   rst_evt   = i_external_master_reset | i_watchdog_timeout;
  wire   bus_wr    = i_bus.wr & ~rst_evt;
  wire   bus_rd    = i_bus.rd & ~rst_evt;
  wire   wr_addr   = bus_wr & (i_bus.addr == OFS_ADDRESS);
  wire   wr_data   = bus_wr & (i_bus.addr == OFS_DATA);
  wire   wr_ctrl   = bus_wr & (i_bus.addr == OFS_CONTROL);
  wire   wr_unlock = bus_wr & (i_bus.addr == OFS_UNLOCK);
  wire   wr_flags  = bus_wr & (i_bus.addr == OFS_FLAGS);
  wire   wr_mask   = bus_wr & (i_bus.addr == OFS_INT_MASK);
  wire   wr_prio   = bus_wr & (i_bus.addr == OFS_PRIORITY);
  wire ctrl_t ctrl_w = ctrl_t'(i_bus.wdata);
  wire   busy      = ctrl.write_start;
  wire   armed     = (ul_state == UL_ARMED);
  wire   done      = busy & (cnt == CNT_W'(1));
  wire   clr_done  = wr_flags & i_bus.wdata[DONE_BIT];

  // write start needs the armed unlock and write enable already set
  wire   start_write = wr_ctrl & ctrl_w.write_start & armed
                     & ctrl.erase_write_enable & ~busy;
  wire   start_read  = wr_ctrl & ctrl_w.read_start
                     & ~ctrl_w.program_memory_select
                     & ~busy & ~ctrl.read_start;

  // target space taken from the control value written with the start
  wire space_t sel_space = ctrl_w.config_space_select ? SPACE_CFG
                         : ctrl_w.program_memory_select ? SPACE_PROG
                         : SPACE_DATA;
  wire   sel_data  = (sel_space == SPACE_DATA);

  wire [7:0] mem_at_addr = mem[nvm_address_byte];
  wire [7:0] mem_at_op   = mem[op_addr];

  wire [7:0] ctrl_rd = {ctrl.program_memory_select, ctrl.config_space_select,
                        1'b0, ctrl.row_erase, ctrl.write_error_flag,
                        ctrl.erase_write_enable, ctrl.write_start, ctrl.read_start};
  wire [7:0] flags_rd = {3'b000, nvm_done_flag, 4'b0000};
  wire [7:0] mask_rd  = {3'b000, nvm_done_int_mask, 4'b0000};
  wire [7:0] prio_rd  = {3'b000, nvm_done_priority, 4'b0000};
  // unlock port and unmapped offsets read zero
  wire [7:0] rd_mux = (i_bus.addr == OFS_ADDRESS)  ? nvm_address_byte
                    : (i_bus.addr == OFS_DATA)     ? nvm_data_byte
                    : (i_bus.addr == OFS_CONTROL)  ? ctrl_rd
                    : (i_bus.addr == OFS_FLAGS)    ? flags_rd
                    : (i_bus.addr == OFS_INT_MASK) ? mask_rd
                    : (i_bus.addr == OFS_PRIORITY) ? prio_rd
                    : ZERO_BYTE;

  // ****************************************
  // unlock sequence
  // ****************************************
  always_comb
  begin
    next_ul_state = ul_state;
    case (ul_state)
      UL_IDLE:
        if (wr_unlock && i_bus.wdata == UNLOCK_KEY1)
          next_ul_state = UL_KEY1;
      UL_KEY1:
        if (bus_wr)
          next_ul_state = (wr_unlock && i_bus.wdata == UNLOCK_KEY2)
                        ? UL_ARMED : UL_IDLE;
      UL_ARMED:
        if (bus_wr)
          next_ul_state = UL_IDLE;
      default:
        next_ul_state = UL_IDLE;
    endcase
    if (rst_evt)
      next_ul_state = UL_IDLE;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      ul_state <= UL_IDLE;
    else
      ul_state <= next_ul_state;

  // ****************************************
  // address and data registers
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      nvm_address_byte <= ADDRESS_RESET;
    else if (rst_evt && busy)
      nvm_address_byte <= ADDRESS_RESET;
    else if (wr_addr)
      nvm_address_byte <= i_bus.wdata;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      nvm_data_byte <= DATA_RESET;
    else if (rst_evt && busy)
      nvm_data_byte <= DATA_RESET;
    else if (wr_data)
      nvm_data_byte <= i_bus.wdata;
    else if (ctrl.read_start)
      nvm_data_byte <= rd_cfg ? i_config_byte : mem_at_addr;

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      ctrl <= '0;
    end
    else if (rst_evt)
    begin
      ctrl.row_erase          <= 1'b0;
      ctrl.erase_write_enable <= 1'b0;
      ctrl.write_start        <= 1'b0;
      ctrl.read_start         <= 1'b0;
      if (busy)
        ctrl.write_error_flag <= 1'b1;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl.program_memory_select <= ctrl_w.program_memory_select;
        ctrl.config_space_select   <= ctrl_w.config_space_select;
        ctrl.row_erase             <= ctrl_w.row_erase;
        ctrl.write_error_flag      <= ctrl_w.write_error_flag;
        ctrl.erase_write_enable    <= ctrl_w.erase_write_enable;
      end
      if (start_write)
        ctrl.write_start <= 1'b1;
      else if (done)
        ctrl.write_start <= 1'b0;
      ctrl.read_start <= start_read;
    end

  // ****************************************
  // write timer and operation latch
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      cnt <= '0;
    else if (rst_evt)
      cnt <= '0;
    else if (start_write)
      cnt <= CNT_W'(WRITE_CYCLES);
    else if (busy)
      cnt <= cnt - CNT_W'(1);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      op_space <= SPACE_DATA;
      op_addr  <= ZERO_BYTE;
      op_data  <= ZERO_BYTE;
      op_erase <= 1'b0;
      rd_cfg   <= 1'b0;
    end
    else
    begin
      if (start_write)
      begin
        op_space <= sel_space;
        op_addr  <= nvm_address_byte;
        op_data  <= nvm_data_byte;
        op_erase <= ctrl_w.row_erase;
      end
      if (start_read)
        rd_cfg <= ctrl_w.config_space_select;
    end

  // ****************************************
  // data array, erased at start, programmed at end
  // ****************************************
  always_ff @(posedge i_ref_clk)
    if (start_write && sel_data)
      mem[nvm_address_byte] <= ERASED_BYTE;
    else if (done && !rst_evt && op_space == SPACE_DATA)
      mem[op_addr] <= op_data;

  // ****************************************
  // program and configuration hand-off
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      o_ext_req <= '0;
    else
    begin
      o_ext_req.strobe    <= done && !rst_evt && op_space != SPACE_DATA;
      o_ext_req.space     <= op_space;
      o_ext_req.row_erase <= op_erase;
      o_ext_req.addr      <= op_addr;
      o_ext_req.data      <= op_data;
    end

  // ****************************************
  // interrupt registers
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      nvm_done_flag     <= FLAGS_RESET;
      nvm_done_int_mask <= MASK_RESET;
      nvm_done_priority <= PRIORITY_RESET;
    end
    else
    begin
      if (done && !rst_evt)
        nvm_done_flag <= 1'b1;
      else if (clr_done)
        nvm_done_flag <= 1'b0;
      if (wr_mask)
        nvm_done_int_mask <= i_bus.wdata[DONE_BIT];
      if (wr_prio)
        nvm_done_priority <= i_bus.wdata[DONE_BIT];
    end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_rdata             <= ZERO_BYTE;
      o_irq               <= 1'b0;
      o_nvm_done_priority <= PRIORITY_RESET;
    end
    else
    begin
      o_rdata             <= bus_rd ? rd_mux : ZERO_BYTE;
      o_irq               <= nvm_done_flag & nvm_done_int_mask;
      o_nvm_done_priority <= nvm_done_priority;
    end

  assign o_busy = ctrl.write_start;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // busy cycle count for the duration check
  logic [CNT_W:0] busy_len;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      busy_len <= '0;
    else if (start_write)
      busy_len <= (CNT_W+1)'(1);
    else if (busy)
      busy_len <= busy_len + (CNT_W+1)'(1);

  property p_write_error_flag;
    busy && rst_evt |=> ctrl.write_error_flag && !busy;
  endproperty
  a_write_error_flag: assert property (p_write_error_flag) else $error("write error not flagged");

  property p_unlock_zero;
    bus_rd && i_bus.addr == OFS_UNLOCK |=> o_rdata == ZERO_BYTE;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock read not zero");

  property p_read_byte;
    start_read && !ctrl_w.config_space_select && !rst_evt
      |=> ctrl.read_start ##1 ($past(wr_data) || $past(rst_evt)
          || nvm_data_byte == $past(mem_at_addr));
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("read byte wrong");

  property p_erase_first;
    start_write && sel_data && !rst_evt |=> mem_at_op == ERASED_BYTE;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("no erase");

  property p_program;
    done && !rst_evt && op_space == SPACE_DATA |=> mem_at_op == $past(op_data);
  endproperty
  a_program: assert property (p_program) else $error("byte not programmed");

  property p_prog_space;
    start_write && !ctrl_w.config_space_select && ctrl_w.program_memory_select
      |=> op_space == SPACE_PROG;
  endproperty
  a_prog_space: assert property (p_prog_space) else $error("wrong space");

  property p_cfg_space;
    start_write && ctrl_w.config_space_select |=> op_space == SPACE_CFG;
  endproperty
  a_cfg_space: assert property (p_cfg_space) else $error("not config space");

  property p_need_enable;
    wr_ctrl && ctrl_w.write_start && !ctrl.erase_write_enable && !busy |=> !busy;
  endproperty
  a_need_enable: assert property (p_need_enable) else $error("write without enable");

  property p_enable_drop;
    busy && !done && !rst_evt && wr_ctrl && !ctrl_w.erase_write_enable |=> busy;
  endproperty
  a_enable_drop: assert property (p_enable_drop) else $error("write aborted");

  property p_reg_clear;
    busy && rst_evt |=> nvm_address_byte == ZERO_BYTE && nvm_data_byte == ZERO_BYTE;
  endproperty
  a_reg_clear: assert property (p_reg_clear) else $error("registers kept");

  property p_read_pulse;
    ctrl.read_start |=> !ctrl.read_start;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read start stuck");

  property p_no_prog_read;
    wr_ctrl && ctrl_w.program_memory_select |=> !ctrl.read_start;
  endproperty
  a_no_prog_read: assert property (p_no_prog_read) else $error("program read");

  property p_done_flag;
    done && !rst_evt |=> nvm_done_flag && !busy ##1 (nvm_done_flag || $past(clr_done));
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag lost");

  property p_unlocked;
    !busy ##1 busy |-> $past(armed);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("write without unlock");

  property p_duration;
    busy ##1 !busy && !$past(rst_evt) |-> $past(busy_len) == (CNT_W+1)'(WRITE_CYCLES);
  endproperty
  a_duration: assert property (p_duration) else $error("write time wrong");

endmodule : nvm_access_control

// ===== nvm_far_store.sv
module nvm_far_store (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rstn,
  input  wire nvm_access_pkg::ext_req_t  i_ext_req,
  output logic [7:0]                     o_count,
  output nvm_access_pkg::ext_req_t       o_last
);
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_access_pkg::*;

  // ****************************************
  // program and configuration store
  // ****************************************
  // records every completed far write
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_count <= 8'h00;
      o_last  <= '0;
    end
    else if (i_ext_req.strobe)
    begin
      o_count <= o_count + 8'h01;
      o_last  <= i_ext_req;
    end
  end
endmodule : nvm_far_store

// ===== tb_nvm_access_control.sv
module tb_nvm_access_control;
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_access_pkg::*;

  localparam int WC = 8;
  logic       i_ref_clk = 1'b0;
  logic       i_rstn = 1'b0;
  reg_req_t   i_bus = '0;
  logic       i_external_master_reset = 1'b0;
  logic       i_watchdog_timeout = 1'b0;
  logic [7:0] i_config_byte = 8'h00;
  logic [7:0] o_rdata;
  logic       o_irq;
  logic       o_nvm_done_priority;
  logic       o_busy;
  ext_req_t   o_ext_req;
  logic [7:0] ext_count;
  ext_req_t   ext_last;
  int         err_total = 0;
  int         cmp_count = 0;
  int         seed = 40;
  int         busy_n = 0;
  logic [7:0] a;
  logic [7:0] d;
  logic [7:0] n0;
  logic [7:0] ctls [3] = '{8'h94, 8'hC4, 8'h44};

  nvm_access_control #(.WRITE_CYCLES(WC)) DUT (
    .i_ref_clk               (i_ref_clk),
    .i_rstn                  (i_rstn),
    .i_bus                   (i_bus),
    .i_external_master_reset (i_external_master_reset),
    .i_watchdog_timeout      (i_watchdog_timeout),
    .i_config_byte           (i_config_byte),
    .o_rdata                 (o_rdata),
    .o_irq                   (o_irq),
    .o_nvm_done_priority     (o_nvm_done_priority),
    .o_busy                  (o_busy),
    .o_ext_req               (o_ext_req)
  );

  nvm_far_store far (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ext_req (o_ext_req),
    .o_count   (ext_count),
    .o_last    (ext_last)
  );

  initial
  begin
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  always @(negedge i_ref_clk)
    if (o_busy === 1'b1)
      busy_n++;

  // ****************************************
  // helpers
  // ****************************************
  function automatic space_t exp_space(input logic [7:0] ctl);
    if (ctl[6])
      return SPACE_CFG;
    return ctl[7] ? SPACE_PROG : SPACE_DATA;
  endfunction : exp_space

  task automatic test_done();
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, bus released at the edge that takes it
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge i_ref_clk);
    i_bus <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    i_bus <= '0;
  endtask : wr

  // releases the bus, ends at a falling edge
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      i_bus <= '0;
    end
    @(negedge i_ref_clk);
  endtask : idle

  task automatic rchk(input logic [3:0] ad, input logic [7:0] exp, input string what);
    @(posedge i_ref_clk);
    i_bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    idle(1);
    chk(o_rdata, exp, what);
  endtask : rchk

  task automatic start(input logic [7:0] ctl);
    wr(OFS_CONTROL, ctl);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    busy_n = 0;
    wr(OFS_CONTROL, ctl | 8'h02);
    idle(1);
  endtask : start

  task automatic wait_done(input logic irq_exp);
    int n;
    n = 0;
    while (o_busy === 1'b1 && n < WC + 20)
    begin
      n++;
      @(negedge i_ref_clk);
    end
    if (n >= WC + 20)
    begin
      err_total++;
      test_done();
    end
    chk(8'(busy_n), 8'(WC), "write duration");
    @(negedge i_ref_clk);
    chk({7'h00, o_irq}, {7'h00, irq_exp}, "irq level");
    rchk(OFS_FLAGS, 8'h10, "done flag");
    wr(OFS_FLAGS, 8'h10);
    idle(2);
    chk({7'h00, o_irq}, 8'h00, "irq after clear");
  endtask : wait_done

  task automatic read_back(input logic [7:0] ad, input logic [7:0] exp);
    wr(OFS_ADDRESS, ad);
    wr(OFS_CONTROL, 8'h01);
    idle(1);
    rchk(OFS_DATA, exp, "read back");
    rchk(OFS_CONTROL, 8'h00, "read start cleared");
  endtask : read_back

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rchk(OFS_ADDRESS, ADDRESS_RESET, "address reset");
    rchk(OFS_DATA, DATA_RESET, "data reset");
    rchk(OFS_FLAGS, 8'h00, "flags reset");
    rchk(OFS_INT_MASK, 8'h00, "mask reset");
    rchk(OFS_PRIORITY, 8'h10, "priority reset");
    chk({7'h00, o_nvm_done_priority}, 8'h01, "priority pin");
    for (int i = 7; i < 16; i++)
      rchk(4'(i), 8'h00, "unmapped");
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    idle(1);
    rchk(OFS_UNLOCK, ZERO_BYTE, "unlock port");
    wr(OFS_PRIORITY, 8'h00);
    idle(2);
    chk({7'h00, o_nvm_done_priority}, 8'h00, "priority write");
    wr(OFS_INT_MASK, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      d = 8'($random(seed));
      wr(OFS_ADDRESS, a);
      wr(OFS_DATA, d);
      start(8'h04);
      chk({7'h00, o_busy}, 8'h01, "busy after unlock");
      rchk(OFS_CONTROL, 8'h06, "control while busy");
      wr(OFS_CONTROL, 8'h00);
      wait_done(1'b1);
      read_back(a, d);
    end
    chk(ext_count, 8'h00, "no far write for data");
    wr(OFS_DATA, 8'h3C);
    start(8'h00);
    chk({7'h00, o_busy}, 8'h00, "start without enable");
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_DATA, 8'h3C);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    wr(OFS_CONTROL, 8'h06);
    idle(1);
    chk({7'h00, o_busy}, 8'h00, "broken unlock");
    wr(OFS_CONTROL, 8'h00);
    read_back(a, d);
    wr(OFS_DATA, 8'h5A);
    wr(OFS_CONTROL, 8'h81);
    idle(1);
    rchk(OFS_DATA, 8'h5A, "program read ignored");
    rchk(OFS_CONTROL, 8'h80, "read start refused");
    d = 8'($random(seed));
    @(posedge i_ref_clk);
    i_config_byte <= d;
    wr(OFS_CONTROL, 8'h41);
    idle(1);
    rchk(OFS_DATA, d, "config read");
    wr(OFS_INT_MASK, 8'h00);
    foreach (ctls[k])
    begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      n0 = ext_count;
      wr(OFS_ADDRESS, a);
      wr(OFS_DATA, d);
      start(ctls[k]);
      wait_done(1'b0);
      chk(ext_count, n0 + 8'h01, "far strobe");
      chk({6'h00, ext_last.space}, {6'h00, exp_space(ctls[k])}, "far space");
      chk(ext_last.addr, a, "far address");
      chk(ext_last.data, d, "far data");
      chk({7'h00, ext_last.row_erase}, {7'h00, ctls[k][4]}, "far row erase");
    end
    wr(OFS_CONTROL, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      a = 8'($random(seed));
      wr(OFS_ADDRESS, a);
      wr(OFS_DATA, 8'h77);
      start(8'h04);
      idle(2);
      @(posedge i_ref_clk);
      if (k == 1)
        i_external_master_reset <= 1'b1;
      else
        i_watchdog_timeout <= 1'b1;
      @(posedge i_ref_clk);
      i_external_master_reset <= 1'b0;
      i_watchdog_timeout <= 1'b0;
      idle(1);
      chk({7'h00, o_busy}, 8'h00, "write cut short");
      rchk(OFS_CONTROL, 8'h08, "write error flag");
      rchk(OFS_ADDRESS, 8'h00, "address cleared");
      rchk(OFS_DATA, 8'h00, "data cleared");
      rchk(OFS_FLAGS, 8'h00, "no done flag");
      wr(OFS_CONTROL, 8'h00);
      read_back(a, ERASED_BYTE);
    end
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    test_done();
  end
endmodule : tb_nvm_access_control
